/* verilog/bscu_core.sv */
// branch, skip and compare unit of the core's control flow
`timescale 1ns/100ps

module bscu_core #(
  parameter int PC_W = bscu_pkg::PC_W
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // instruction issue
  input  wire logic              req_valid,
  input  bscu_pkg::bscu_req_t    req,
  output logic                   req_ready,
  // current condition flags
  input  wire logic [7:0]        flags_in,
  // completion towards program counter and flags
  output bscu_pkg::bscu_resp_t   resp
);
  import bscu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check

  // the records carry the package width, so the parameter must agree
  // a narrower pc would also clip the sign-extended branch offset
  // the offset width bounds the smallest usable pc width
  // widening it alone is not enough: the package width must follow
  if (PC_W != bscu_pkg::PC_W || PC_W < OFF_W + 1) begin : g_bad_width
    $error("bscu_core: PC_W does not fit the request and response records");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // step the program counter by a small constant
  // wraps at the top of program space, as the counter itself would
  // the step is an int so callers can pass the package constants
  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc,
                                              input int step);
    pc_step = pc + PC_W'(step);
  endfunction

  // flag test of the conditional branches
  // every form reads only the flags sampled with the request
  // the generic forms index the flag byte directly
  // same-or-higher and lower share the carry test of the carry forms
  // the signed forms combine negative and overflow, not the sign flag
  // unknown codes never branch
  function automatic logic branch_cond(input bscu_op_t op,
                                       input logic [2:0] sel,
                                       input logic [7:0] f);
    logic nv;
    nv = f[FLAG_N] ^ f[FLAG_V];
    unique case (op)
      OP_BRANCH_FLAG_BIT_SET:         branch_cond = f[sel];
      OP_BRANCH_FLAG_BIT_CLEAR:       branch_cond = !f[sel];
      OP_BRANCH_EQUAL:                branch_cond = f[FLAG_Z];
      OP_BRANCH_NOT_EQUAL:            branch_cond = !f[FLAG_Z];
      OP_BRANCH_CARRY_SET:            branch_cond = f[FLAG_C];
      OP_BRANCH_CARRY_CLEAR:          branch_cond = !f[FLAG_C];
      OP_BRANCH_UNSIGNED_HIGHER_SAME: branch_cond = !f[FLAG_C];
      OP_BRANCH_UNSIGNED_LOWER:       branch_cond = f[FLAG_C];
      OP_BRANCH_MINUS:                branch_cond = f[FLAG_N];
      OP_BRANCH_PLUS:                 branch_cond = !f[FLAG_N];
      OP_BRANCH_SIGNED_GREATER_EQUAL: branch_cond = !nv;
      OP_BRANCH_SIGNED_LESS:          branch_cond = nv;
      OP_BRANCH_HALF_CARRY_SET:       branch_cond = f[FLAG_H];
      OP_BRANCH_HALF_CARRY_CLEAR:     branch_cond = !f[FLAG_H];
      OP_BRANCH_TRANSFER_BIT_SET:     branch_cond = f[FLAG_T];
      OP_BRANCH_TRANSFER_BIT_CLEAR:   branch_cond = !f[FLAG_T];
      OP_BRANCH_OVERFLOW_SET:         branch_cond = f[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR:       branch_cond = !f[FLAG_V];
      OP_BRANCH_IRQ_ENABLED:          branch_cond = f[FLAG_I];
      OP_BRANCH_IRQ_DISABLED:         branch_cond = !f[FLAG_I];
      default:                        branch_cond = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operation classes

  wire logic is_cmp;
  wire logic is_skip;
  wire logic is_branch;
  wire logic is_ret;
  wire logic is_interrupt_return;

  // group the operation codes
  // returns and interrupt return share the reload path
  // is_ret includes the interrupt return
  // the branch group relies on contiguous codes in the package
  // anything outside these groups behaves as a one-cycle no-op
  assign is_cmp    = (req.op == OP_COMPARE_REGISTERS) ||
                     (req.op == OP_COMPARE_WITH_CARRY_IN) ||
                     (req.op == OP_COMPARE_IMMEDIATE);
  assign is_skip   = (req.op == OP_COMPARE_SKIP_EQUAL) ||
                     (req.op == OP_SKIP_REG_BIT_CLEAR) ||
                     (req.op == OP_SKIP_REG_BIT_SET) ||
                     (req.op == OP_SKIP_IO_BIT_CLEAR) ||
                     (req.op == OP_SKIP_IO_BIT_SET);
  assign is_branch = (req.op >= OP_BRANCH_FLAG_BIT_SET) &&
                     (req.op <= OP_BRANCH_IRQ_DISABLED);
  assign is_interrupt_return   = (req.op == OP_INTERRUPT_RETURN);
  assign is_ret    = (req.op == OP_SUBROUTINE_RETURN) || is_interrupt_return;

  ////////////////////////////////////////////////////////////////////////////
  // compare datapath

  wire logic [7:0] cmp_rhs;
  wire logic       cmp_cin;
  wire logic [8:0] cmp_diff;
  wire logic [4:0] cmp_half;
  wire logic [7:0] cmp_res;
  wire logic       cmp_z;
  wire logic       cmp_v;
  logic      [7:0] cmp_flags;

  // subtract without storing the result
  // nine bits keep the borrow out of bit 7 as the carry flag
  // the five-bit copy of the low nibble gives the half-carry borrow
  // only the carry-in form adds the old carry into the borrow chain
  // the immediate form reuses the register path with another operand
  // the difference never leaves this block
  assign cmp_rhs  = (req.op == OP_COMPARE_IMMEDIATE) ? req.imm : req.rr;
  assign cmp_cin  = (req.op == OP_COMPARE_WITH_CARRY_IN) & flags_in[FLAG_C];
  assign cmp_diff = {1'b0, req.rd} - {1'b0, cmp_rhs} - {8'h00, cmp_cin};
  assign cmp_half = {1'b0, req.rd[3:0]} - {1'b0, cmp_rhs[3:0]} - {4'h0, cmp_cin};
  assign cmp_res  = cmp_diff[7:0];

  // carry-in compare only keeps Z when the earlier bytes were equal
  // that way a chain of compares over a multi-byte value yields one Z
  // overflow is a borrow that flips the sign of the difference
  assign cmp_z = (cmp_res == 8'h00) &&
                 ((req.op != OP_COMPARE_WITH_CARRY_IN) || flags_in[FLAG_Z]);
  assign cmp_v = (req.rd[7] & ~cmp_rhs[7] & ~cmp_res[7]) |
                 (~req.rd[7] & cmp_rhs[7] & cmp_res[7]);

  // new flags: Z N V C H change, S T I stay
  // starting from the current byte keeps the untouched bits exact
  // Z N V C H are rewritten from the difference, with Z also gated by the old Z on the carry-in form
  always_comb begin
    cmp_flags         = flags_in;
    cmp_flags[FLAG_Z] = cmp_z;
    cmp_flags[FLAG_N] = cmp_res[7];
    cmp_flags[FLAG_V] = cmp_v;
    cmp_flags[FLAG_C] = cmp_diff[8];
    cmp_flags[FLAG_H] = cmp_half[4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // skip and branch conditions

  wire logic reg_bit;
  wire logic skip_cond;
  wire logic br_cond;

  // pick the tested register bit
  // the register forms test the source operand, not the destination
  // bit_sel picks one of eight bits; no other range exists
  assign reg_bit = req.rr[req.bit_sel];

  // skip decision per skip form
  // the I/O bit arrives already read, so this block never waits for it
  // compare-skip-equal uses the full byte compare, not the subtractor
  // a false condition falls through to the plain next address
  assign skip_cond =
    ((req.op == OP_COMPARE_SKIP_EQUAL) && (req.rd == req.rr)) ||
    ((req.op == OP_SKIP_REG_BIT_CLEAR) && !reg_bit) ||
    ((req.op == OP_SKIP_REG_BIT_SET) && reg_bit) ||
    ((req.op == OP_SKIP_IO_BIT_CLEAR) && !req.io_bit) ||
    ((req.op == OP_SKIP_IO_BIT_SET) && req.io_bit);

  assign br_cond = is_branch && branch_cond(req.op, req.bit_sel, flags_in);

  ////////////////////////////////////////////////////////////////////////////
  // target and cycle count

  wire logic [PC_W-1:0]  off_ext;
  wire logic [PC_W-1:0]  pc_next;
  wire logic [PC_W-1:0]  pc_skip;
  wire logic [PC_W-1:0]  pc_branch;
  wire logic [PC_W-1:0]  tgt;
  wire logic [CNT_W-1:0] cycles;
  logic      [7:0]       interrupt_return_flags;

  // signed offset and the candidate targets
  // the offset is sign-extended first so backward branches wrap right
  // skip targets count from this instruction, not the next one
  // the skip length depends on whether the next instruction is two words
  // all arithmetic wraps at the program counter width
  assign off_ext   = {{(PC_W-OFF_W){req.offset[OFF_W-1]}}, req.offset};
  assign pc_next   = pc_step(req.pc, STEP_NEXT);
  assign pc_skip   = req.next_two_word ? pc_step(req.pc, STEP_SKIP_TWO)
                                       : pc_step(req.pc, STEP_SKIP_ONE);
  assign pc_branch = pc_next + off_ext;

  // choose the new program counter
  // returns win over everything; the stack word is taken as is
  // skips are tested before branches, which cannot both be true
  // an untaken branch or failed skip steps to the next word
  assign tgt = is_ret                  ? req.ret_addr :
               (is_skip && skip_cond)  ? pc_skip :
               br_cond                 ? pc_branch :
                                         pc_next;

  // cycles the instruction occupies
  // the count runs from the accepting edge to the completion pulse
  // compares and no-ops finish on the very next edge
  // returns always take the full four cycles
  assign cycles = is_ret    ? CYC_RET :
                  is_skip   ? (!skip_cond        ? CYC_SKIP_NO :
                               req.next_two_word ? CYC_SKIP_TWO
                                                 : CYC_SKIP_ONE) :
                  is_branch ? (br_cond ? CYC_BR_TAKEN : CYC_BR_NOT) :
                              CYC_CMP;

  // interrupt return raises the global enable
  // all other flag bits are passed back exactly as they came in
  // subroutine return leaves the flag byte unwritten
  always_comb begin
    interrupt_return_flags         = flags_in;
    interrupt_return_flags[FLAG_I] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // result record

  bscu_resp_t res;
  wire logic  take;

  assign take = req_valid && req_ready;

  // skips and branches write no flag; only compares and interrupt_return do
  // done and pc_load are set together here; at the port pc_load stays high after the done pulse
  // skipped and taken are for tracing only and drive nothing
  // the flag byte is valid only while flags_we is high
  // only compares and interrupt return raise flags_we
  always_comb begin
    res          = '0;
    res.done     = 1'b1;
    res.pc_load  = 1'b1;
    res.pc       = tgt;
    res.flags_we = is_cmp || is_interrupt_return;
    res.flags    = is_interrupt_return ? interrupt_return_flags : (is_cmp ? cmp_flags : flags_in);
    res.skipped  = is_skip && skip_cond;
    res.taken    = br_cond;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  bscu_state_t      state_q;
  bscu_state_t      state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  bscu_resp_t       pend_q;
  bscu_resp_t       pend_d;
  bscu_resp_t       resp_q;
  bscu_resp_t       resp_d;
  logic             ready_q;
  logic             ready_d;

  // one-cycle ops finish at once, longer ones wait out their count
  // the request port is closed while a long instruction runs,
  // so the core cannot issue past a pending branch or return
  // the result is held in pend_q and released on the last count
  // the counter is loaded with the count less the accepting cycle
  // and holds one in the cycle before the edge that publishes the result
  // done is a one-cycle pulse; the other fields stand until the next
  // completion so the core may read them late
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    pend_d  = pend_q;
    resp_d  = resp_q;
    ready_d = ready_q;
    resp_d.done = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          if (cycles == CYC_LAST) begin
            resp_d = res;
          end else begin
            pend_d  = res;
            cnt_d   = cycles - CYC_LAST;
            state_d = ST_WAIT;
            ready_d = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        cnt_d = cnt_q - CYC_LAST;
        if (cnt_q == CYC_LAST) begin
          resp_d  = pend_q;
          state_d = ST_IDLE;
          ready_d = 1'b1;
        end
      end
    endcase
  end

  // state registers
  // reset opens the request port and clears the response record
  // an instruction in flight at reset is dropped without completion
  // no clock enable: every register updates on every edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      pend_q  <= '0;
      resp_q  <= '0;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pend_q  <= pend_d;
      resp_q  <= resp_d;
      ready_q <= ready_d;
    end
  end

  // outputs straight from flops
  // no logic sits between the registers and the ports
  assign req_ready = ready_q;
  assign resp      = resp_q;

endmodule

/* verilog/bscu_pkg.sv */
// shared types and constants of the branch, skip and compare unit
package bscu_pkg;

  // program counter and operand widths
  localparam int PC_W  = 16;
  localparam int OFF_W = 7;
  localparam int CNT_W = 3;

  // bit positions inside the condition flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // cycle counts per outcome
  localparam logic [CNT_W-1:0] CYC_CMP      = 3'h1;
  localparam logic [CNT_W-1:0] CYC_SKIP_NO  = 3'h1;
  localparam logic [CNT_W-1:0] CYC_SKIP_ONE = 3'h2;
  localparam logic [CNT_W-1:0] CYC_SKIP_TWO = 3'h3;
  localparam logic [CNT_W-1:0] CYC_BR_NOT   = 3'h1;
  localparam logic [CNT_W-1:0] CYC_BR_TAKEN = 3'h2;
  localparam logic [CNT_W-1:0] CYC_RET      = 3'h4;
  localparam logic [CNT_W-1:0] CYC_LAST     = 3'h1;

  // program counter steps
  localparam int STEP_NEXT     = 1;
  localparam int STEP_SKIP_ONE = 2;
  localparam int STEP_SKIP_TWO = 3;

  // operations handled by the unit
  typedef enum logic [4:0] {
    OP_NONE                        = 5'h00,
    OP_COMPARE_SKIP_EQUAL          = 5'h01,
    OP_COMPARE_REGISTERS           = 5'h02,
    OP_COMPARE_WITH_CARRY_IN       = 5'h03,
    OP_COMPARE_IMMEDIATE           = 5'h04,
    OP_SKIP_REG_BIT_CLEAR          = 5'h05,
    OP_SKIP_REG_BIT_SET            = 5'h06,
    OP_SKIP_IO_BIT_CLEAR           = 5'h07,
    OP_SKIP_IO_BIT_SET             = 5'h08,
    OP_BRANCH_FLAG_BIT_SET         = 5'h09,
    OP_BRANCH_FLAG_BIT_CLEAR       = 5'h0a,
    OP_BRANCH_EQUAL                = 5'h0b,
    OP_BRANCH_NOT_EQUAL            = 5'h0c,
    OP_BRANCH_CARRY_SET            = 5'h0d,
    OP_BRANCH_CARRY_CLEAR          = 5'h0e,
    OP_BRANCH_UNSIGNED_HIGHER_SAME = 5'h0f,
    OP_BRANCH_UNSIGNED_LOWER       = 5'h10,
    OP_BRANCH_MINUS                = 5'h11,
    OP_BRANCH_PLUS                 = 5'h12,
    OP_BRANCH_SIGNED_GREATER_EQUAL = 5'h13,
    OP_BRANCH_SIGNED_LESS          = 5'h14,
    OP_BRANCH_HALF_CARRY_SET       = 5'h15,
    OP_BRANCH_HALF_CARRY_CLEAR     = 5'h16,
    OP_BRANCH_TRANSFER_BIT_SET     = 5'h17,
    OP_BRANCH_TRANSFER_BIT_CLEAR   = 5'h18,
    OP_BRANCH_OVERFLOW_SET         = 5'h19,
    OP_BRANCH_OVERFLOW_CLEAR       = 5'h1a,
    OP_BRANCH_IRQ_ENABLED          = 5'h1b,
    OP_BRANCH_IRQ_DISABLED         = 5'h1c,
    OP_SUBROUTINE_RETURN           = 5'h1d,
    OP_INTERRUPT_RETURN            = 5'h1e
  } bscu_op_t;

  // one issued instruction with its operands
  typedef struct packed {
    bscu_op_t            op;
    logic [7:0]          rd;
    logic [7:0]          rr;
    logic [7:0]          imm;
    logic [2:0]          bit_sel;
    logic                io_bit;
    logic [OFF_W-1:0]    offset;
    logic                next_two_word;
    logic [PC_W-1:0]     pc;
    logic [PC_W-1:0]     ret_addr;
  } bscu_req_t;

  // completion record
  typedef struct packed {
    logic                done;
    logic                pc_load;
    logic [PC_W-1:0]     pc;
    logic                flags_we;
    logic [7:0]          flags;
    logic                skipped;
    logic                taken;
  } bscu_resp_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } bscu_state_t;

endpackage

/* testbench/bscu_core_chk.sv */
// assertion checker on the ports of the branch, skip and compare unit
`timescale 1ns/100ps
module bscu_core_chk #(
  parameter int PC_W = bscu_pkg::PC_W
) (
  // clock, reset and all ports of the unit
  input wire logic           clock,
  input wire logic           reset_n,
  input wire logic           req_valid,
  input bscu_pkg::bscu_req_t req,
  input wire logic           req_ready,
  input wire logic [7:0]     flags_in,
  input bscu_pkg::bscu_resp_t resp
);
  import bscu_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // request in flight and cycles since it was taken
  logic            take;
  bscu_req_t       rq_q;
  logic [7:0]      f_q;
  logic [2:0]      cnt_q;
  logic            is_cmp;
  logic            is_skip;
  logic            is_br;
  logic            is_ret;
  logic            sk_c;
  logic [PC_W-1:0] br_pc;
  logic [PC_W-1:0] sk_pc;
  assign take = req_valid && req_ready;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rq_q <= '0;
      f_q <= '0;
      cnt_q <= '0;
    end else if (take) begin
      rq_q <= req;
      f_q <= flags_in;
      cnt_q <= 3'h1;
    end else if (cnt_q != 3'h7) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // decode of the captured operation and its expected targets
  assign is_cmp = rq_q.op inside {[OP_COMPARE_REGISTERS:OP_COMPARE_IMMEDIATE]};
  assign is_skip = rq_q.op inside {OP_COMPARE_SKIP_EQUAL,
                                   [OP_SKIP_REG_BIT_CLEAR:OP_SKIP_IO_BIT_SET]};
  assign is_br = rq_q.op inside {[OP_BRANCH_FLAG_BIT_SET:OP_BRANCH_IRQ_DISABLED]};
  assign is_ret = rq_q.op inside {OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN};
  assign sk_c = (rq_q.op == OP_COMPARE_SKIP_EQUAL) ? (rq_q.rd == rq_q.rr) :
                (rq_q.op inside {OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET}) ?
                (rq_q.rr[rq_q.bit_sel] ^ (rq_q.op == OP_SKIP_REG_BIT_CLEAR)) :
                (rq_q.io_bit ^ (rq_q.op == OP_SKIP_IO_BIT_CLEAR));
  assign sk_pc = rq_q.pc + PC_W'(sk_c ? (rq_q.next_two_word ? 3 : 2) : 1);
  assign br_pc = rq_q.pc + PC_W'(1) + PC_W'(signed'(rq_q.offset));
  // return takes four cycles with the unit refusing meanwhile
  sequence s_ret_take;
    take && (req.op inside {OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN});
  endsequence
  sequence s_ret_busy;
    (!req_ready && !resp.done) [*3] ##1 (resp.done && req_ready);
  endsequence
  chk_cmp_one_cycle: assert property (
    take && (req.op inside {[OP_COMPARE_REGISTERS:OP_COMPARE_IMMEDIATE]})
    |=> resp.done && resp.flags_we) else $error("compare not done in one cycle");
  chk_cmp_keeps_rest: assert property (
    resp.done && is_cmp |-> resp.flags[FLAG_S] == f_q[FLAG_S] && resp.flags[7:6] == f_q[7:6])
    else $error("compare changed a flag outside its set");
  chk_ctl_no_flags: assert property (
    resp.done && (is_br || is_skip) |-> !resp.flags_we) else $error("flags written");
  chk_branch_target: assert property (
    resp.done && is_br |-> resp.pc == (resp.taken ? br_pc : rq_q.pc + PC_W'(1))
    && cnt_q == (resp.taken ? 3'h2 : 3'h1)) else $error("branch target or timing");
  chk_skip_target: assert property (
    resp.done && is_skip |-> resp.pc == sk_pc
    && cnt_q == (sk_c ? (rq_q.next_two_word ? 3'h3 : 3'h2) : 3'h1)) else $error("skip wrong");
  chk_ret_busy: assert property (
    s_ret_take |=> s_ret_busy) else $error("return timing wrong");
  chk_ret_target: assert property (
    resp.done && is_ret |-> resp.pc == rq_q.ret_addr
    && resp.flags_we == (rq_q.op == OP_INTERRUPT_RETURN)) else $error("return target wrong");
  chk_interrupt_return_sets_i: assert property (
    resp.done && rq_q.op == OP_INTERRUPT_RETURN |-> resp.flags == (f_q | 8'h80))
    else $error("interrupt enable not set on return");
  chk_signed_taken: assert property (
    resp.done && (rq_q.op inside {OP_BRANCH_SIGNED_GREATER_EQUAL, OP_BRANCH_SIGNED_LESS})
    |-> resp.taken == (f_q[FLAG_N] ^ f_q[FLAG_V] ^ (rq_q.op == OP_BRANCH_SIGNED_GREATER_EQUAL)))
    else $error("signed branch decision wrong");
endmodule

bind bscu_core bscu_core_chk #(.PC_W(PC_W)) u_chk (
  .clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .flags_in(flags_in), .resp(resp));

/* testbench/bscu_imem.sv */
// program memory model offering one instruction word at a time
`timescale 1ns/100ps
module bscu_imem (
  // clock and reset
  input wire logic           clock,
  input wire logic           reset_n,
  // word handed over by the bench
  input wire logic           load,
  input bscu_pkg::bscu_req_t word,
  // issue side of the unit
  input wire logic           req_ready,
  output logic               req_valid,
  output bscu_pkg::bscu_req_t req
);
  import bscu_pkg::*;
  // offer held until taken; released lines show the inverse of the word
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      req_valid <= 1'b0;
      req <= '0;
    end else if (load) begin
      req_valid <= #1 1'b1;
      req <= #1 word;
    end else if (req_valid && req_ready) begin
      req_valid <= #1 1'b0;
      req <= #1 ~req;
    end
  end
endmodule

/* testbench/test_branch_skip_compare_unit.sv */
// self-checking bench of the branch, skip and compare unit
`timescale 1ns/100ps
module test_branch_skip_compare_unit;
  import bscu_pkg::*;
  logic       clock, reset_n, ld, req_valid, req_ready;
  logic [7:0] flags_in;
  bscu_req_t  word, req;
  bscu_resp_t resp;
  int         n_fail, cmp_count, ncyc;
  bscu_imem u_mem (.clock(clock), .reset_n(reset_n), .load(ld), .word(word),
    .req_ready(req_ready), .req_valid(req_valid), .req(req));
  bscu_core u_dut (.clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .flags_in(flags_in), .resp(resp));
  // comparison bookkeeping and the closing report
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one instruction through the memory model; ncyc ends as cycles from take to done
  task automatic run(input bscu_req_t w, input logic [7:0] f);
    word = w;
    flags_in = f;
    ld = 1'b1;
    @(posedge clock);
    #1 ld = 1'b0;
    ncyc = 0;
    do begin
      @(posedge clock);
      #1 ncyc++;
    end while (resp.done !== 1'b1 && ncyc < 12);
    if (ncyc >= 12) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // expected flags of a compare: difference formed, Z N V C H updated
  function automatic logic [7:0] exp_cmp(bscu_op_t op, logic [7:0] a, logic [7:0] b,
                                         logic [7:0] f);
    logic       ci;
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] e;
    ci = (op == OP_COMPARE_WITH_CARRY_IN) & f[FLAG_C];
    r = {1'b0, a} - {1'b0, b} - 9'(ci);
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(ci);
    e = f;
    e[FLAG_C] = r[8];
    e[FLAG_H] = h[4];
    e[FLAG_N] = r[7];
    e[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    e[FLAG_Z] = (r[7:0] == 8'h00) & (op != OP_COMPARE_WITH_CARRY_IN || f[FLAG_Z]);
    return e;
  endfunction
  // expected branch decision from the flags
  function automatic logic exp_taken(bscu_op_t op, logic [2:0] s, logic [7:0] f);
    case (op)
      OP_BRANCH_FLAG_BIT_SET: return f[s];
      OP_BRANCH_FLAG_BIT_CLEAR: return !f[s];
      OP_BRANCH_EQUAL: return f[FLAG_Z];
      OP_BRANCH_NOT_EQUAL: return !f[FLAG_Z];
      OP_BRANCH_CARRY_SET, OP_BRANCH_UNSIGNED_LOWER: return f[FLAG_C];
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_UNSIGNED_HIGHER_SAME: return !f[FLAG_C];
      OP_BRANCH_MINUS: return f[FLAG_N];
      OP_BRANCH_PLUS: return !f[FLAG_N];
      OP_BRANCH_SIGNED_GREATER_EQUAL: return !(f[FLAG_N] ^ f[FLAG_V]);
      OP_BRANCH_SIGNED_LESS: return f[FLAG_N] ^ f[FLAG_V];
      OP_BRANCH_HALF_CARRY_SET: return f[FLAG_H];
      OP_BRANCH_HALF_CARRY_CLEAR: return !f[FLAG_H];
      OP_BRANCH_TRANSFER_BIT_SET: return f[FLAG_T];
      OP_BRANCH_TRANSFER_BIT_CLEAR: return !f[FLAG_T];
      OP_BRANCH_OVERFLOW_SET: return f[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR: return !f[FLAG_V];
      OP_BRANCH_IRQ_ENABLED: return f[FLAG_I];
      default: return !f[FLAG_I];
    endcase
  endfunction
  // all three compares over borrow, overflow, zero and carry-in cases
  task automatic test_compare();
    bscu_req_t  w;
    logic [7:0] v [5][3];
    v = '{'{8'h10, 8'h20, 8'h00}, '{8'h80, 8'h01, 8'h00}, '{8'h35, 8'h35, 8'h02},
          '{8'h35, 8'h34, 8'h03}, '{8'h35, 8'h34, 8'h21}};
    for (int i = 2; i <= 4; i++) begin
      foreach (v[j]) begin
        w = '0;
        w.op = bscu_op_t'(i);
        w.rd = v[j][0];
        w.rr = v[j][1];
        w.imm = v[j][1];
        run(w, v[j][2]);
        check(ncyc == 1 && resp.flags_we === 1'b1, "compare timing");
        check(resp.pc === 16'h0001 && resp.pc_load === 1'b1, "compare pc");
        check(resp.flags === exp_cmp(w.op, v[j][0], v[j][1], v[j][2]), "flags");
      end
    end
    $display("test compare done");
  endtask
  // every skip, condition true and false, over one- and two-word targets
  task automatic test_skip();
    bscu_req_t w;
    logic      sk;
    for (int i = 1; i <= 8; i++) begin
      for (int b = 0; b < 4; b++) begin
        if (i inside {[2:4]}) continue;
        w = '0;
        w.op = bscu_op_t'(i);
        w.bit_sel = 3'h3;
        w.rr = b[0] ? 8'h08 : 8'hf7;
        w.rd = (i == 1) ? 8'h08 : w.rr;
        w.io_bit = b[0];
        w.next_two_word = b[1];
        w.pc = 16'hfffe;
        sk = b[0] ^ (i == 5 || i == 7);
        run(w, 8'hff);
        check(resp.flags_we === 1'b0, "skip wrote flags");
        check(ncyc == (sk ? 2 + b[1] : 1), "skip cycles");
        check(resp.skipped === sk, "skip flag");
        check(resp.pc === 16'hfffe + 16'(sk ? 2 + b[1] : 1), "skip pc");
      end
    end
    $display("test skip done");
  endtask
  // every branch over several flag patterns, forward and backward offsets
  task automatic test_branch();
    bscu_req_t  w;
    logic [7:0] fl [6];
    logic       t;
    fl = '{8'h00, 8'hff, 8'h55, 8'haa, 8'h0c, 8'h04};
    for (int i = 9; i <= 28; i++) begin
      foreach (fl[j]) begin
        w = '0;
        w.op = bscu_op_t'(i);
        w.bit_sel = 3'(i + j);
        w.offset = j[0] ? 7'h3f : 7'h40;
        w.pc = 16'h0200;
        t = exp_taken(w.op, w.bit_sel, fl[j]);
        run(w, fl[j]);
        check(resp.flags_we === 1'b0 && ncyc == (t ? 2 : 1), "branch cycles");
        check(resp.taken === t, "branch decision");
        check(resp.pc === (t ? (j[0] ? 16'h0240 : 16'h01c1) : 16'h0201), "pc");
      end
    end
    $display("test branch done");
  endtask
  // both returns: stack target, four cycles, interrupt enable on the second
  task automatic test_return();
    bscu_req_t w;
    for (int i = 29; i <= 30; i++) begin
      w = '0;
      w.op = bscu_op_t'(i);
      w.ret_addr = 16'h2468;
      run(w, 8'h21);
      check(ncyc == 4 && resp.pc === 16'h2468, "return target");
      check(resp.flags_we === (i == 30) && (i == 29 || resp.flags === 8'ha1), "ret");
    end
    $display("test return done");
  endtask
  // reset in mid return: ready and cleared response, then a no-op runs normally
  task automatic test_reset();
    bscu_req_t w;
    w = '0;
    w.op = OP_SUBROUTINE_RETURN;
    word = w;
    ld = 1'b1;
    @(posedge clock);
    #1 ld = 1'b0;
    repeat (2) @(posedge clock);
    #1 check(req_ready === 1'b0, "return not busy");
    reset_n = 1'b0;
    #1 check(req_ready === 1'b1 && resp === '0, "reset values");
    @(posedge clock);
    #1 reset_n = 1'b1;
    @(posedge clock);
    #1 check(req_ready === 1'b1 && resp === '0, "values after release");
    w.op = OP_NONE;
    w.pc = 16'h0010;
    run(w, 8'h00);
    check(ncyc == 1 && resp.pc === 16'h0011 && resp.flags_we === 1'b0, "no-op");
    $display("test reset done");
  endtask
  // clock of 4 ns
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // reset, then the scenarios in turn
  initial begin
    reset_n = 1'b0;
    ld = 1'b0;
    word = '0;
    flags_in = 8'h00;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(posedge clock);
    #1 reset_n = 1'b1;
    test_compare();
    test_skip();
    test_branch();
    test_return();
    test_reset();
    print_verdict();
  end
endmodule
